// *** verilog/acg_pkg.sv ***
// Package for the automatic clock gate and pin wake enable block.
// Assumes an AHB-Lite single-slave bus on clock_i, synchronous reset.
package acg_pkg;
  localparam logic [31:0] PIN_WAKE_SOURCE_ENABLE_ADDR    = 32'h4000_4030;
  localparam logic [31:0] AUTO_CLOCK_GATING_CONTROL_ADDR = 32'h4000_40EC;
  localparam logic [31:0] ADDR_MASK      = 32'h0000_0FFC;
  localparam logic [31:0] GATE_CTRL_MASK = 32'h0000_0043;
  localparam logic [31:0] WAKE_MASK      = 32'hD7E7_FFF8;
  localparam logic [31:0] GATE_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] WAKE_RST       = 32'h0000_0000;
  localparam int USB_DIS_BIT  = 6;
  localparam int RAM_DIS_BIT  = 1;
  localparam int ROM_DIS_BIT  = 0;
  localparam int USB_IDLE_CYCLES = 128;
  localparam int RAM_IDLE_CYCLES = 16;
  localparam int ROM_IDLE_CYCLES = 8;
  localparam int CNT_W = 8;
  localparam int WAKE_CARD_OR_BIT = 17;
  localparam int WAKE_CARD_INT_BIT = 18;

  typedef struct packed {
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hsel;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic uart7_receive;
    logic uart7_clear_to_send;
    logic uart6_infrared_receive;
    logic uart5_receive;
    logic general_input_28;
    logic uart3_receive;
    logic uart2_clear_to_send;
    logic uart2_receive;
    logic uart1_receive;
    logic [3:0] card_data_lines;
    logic [6:0] general_input_hi;
    logic external_clock_request_pin;
    logic serial_port1_data_in;
    logic general_input_7;
    logic serial_port2_data_in;
    logic [2:0] general_input_lo;
  } wake_pins_t;

  typedef enum logic [1:0] {
    CG_RUN     = 2'b00,
    CG_STOPPED = 2'b01,
    CG_WAKING  = 2'b10
  } cg_state_t;
endpackage

// *** verilog/client_clock_gate.sv ***
// One gated client: idle counter, stop state machine, run enable.
// Assumes access_i marks a client access in its address phase.
`timescale 1ns/100ps
`default_nettype none
module client_clock_gate #(
  parameter int IDLE_CYCLES = 8
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic disable_i,
  input  wire logic access_i,
  output var  logic clk_run_o,
  output var  logic stall_o
);
  import acg_pkg::*;
  logic [CNT_W-1:0] idle_cnt_r;
  cg_state_t        state_r;

  // Idle counter
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || access_i || disable_i) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != CNT_W'(IDLE_CYCLES)) begin
      idle_cnt_r <= idle_cnt_r + CNT_W'(1);
    end
  end

  // Stop and wake sequencing
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= CG_RUN;
    end else begin
      unique case (state_r)
        CG_RUN: begin
          if (!disable_i && !access_i &&
              idle_cnt_r == CNT_W'(IDLE_CYCLES - 1)) begin
            state_r <= CG_STOPPED;
          end
        end
        CG_STOPPED: begin
          if (access_i || disable_i) begin
            state_r <= CG_WAKING;
          end
        end
        CG_WAKING: begin
          state_r <= CG_RUN;
        end
        default: state_r <= CG_RUN;
      endcase
    end
  end

  assign clk_run_o = (state_r != CG_STOPPED);
  assign stall_o   = (state_r == CG_STOPPED) && access_i;
endmodule
`default_nettype wire

// *** verilog/auto_clock_gate_and_pin_wake_enable.sv ***
// Top: AHB-Lite registers, three client clock gates, pin wake enables.
// Assumes one AHB master, word accesses, clock_i at 40 MHz.
`timescale 1ns/100ps
`default_nettype none
module auto_clock_gate_and_pin_wake_enable (
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  input  wire acg_pkg::ahb_req_t  ahb_i,
  input  wire logic [31:0]        hwdata_i,
  output logic [31:0]             hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  input  wire logic               usb_access_i,
  input  wire logic               ram_access_i,
  input  wire logic               rom_access_i,
  output logic                    usb_clk_en_o,
  output logic                    ram_clk_en_o,
  output logic                    rom_clk_en_o,
  output logic                    client_stall_o,
  input  wire acg_pkg::wake_pins_t wake_pins_i,
  output logic [31:0]             pin_wake_request_o
);
  import acg_pkg::*;
  logic [31:0] gate_ctrl_r;
  logic [31:0] wake_en_r;
  logic        wr_pend_r;
  logic        wr_gate_r;
  logic [31:0] rd_data_nxt;
  logic        sel_gate;
  logic        sel_wake;
  logic        active;
  logic [2:0]  run;
  logic [2:0]  stall;
  logic [31:0] pin_vec;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = ((a & ADDR_MASK) == (r & ADDR_MASK));
  endfunction

  assign active   = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
  assign sel_gate = hit(ahb_i.haddr, AUTO_CLOCK_GATING_CONTROL_ADDR);
  assign sel_wake = hit(ahb_i.haddr, PIN_WAKE_SOURCE_ENABLE_ADDR);

  // Bus data phase
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wr_pend_r   <= 1'b0;
      wr_gate_r   <= 1'b0;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r   <= active && ahb_i.hwrite && (sel_gate || sel_wake);
      wr_gate_r   <= sel_gate;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (active && !ahb_i.hwrite) begin
        hrdata_o <= rd_data_nxt;
      end
    end
  end

  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    if (sel_gate) begin
      rd_data_nxt = gate_ctrl_r;
    end else if (sel_wake) begin
      rd_data_nxt = wake_en_r;
    end
  end

  // Gating control register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      gate_ctrl_r <= GATE_CTRL_RST;
    end else if (wr_pend_r && wr_gate_r) begin
      gate_ctrl_r <= hwdata_i & GATE_CTRL_MASK;
    end
  end

  // Pin wake enable register
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      wake_en_r <= WAKE_RST;
    end else if (wr_pend_r && !wr_gate_r) begin
      wake_en_r <= hwdata_i & WAKE_MASK;
    end
  end

  // Pin mapping onto wake bit positions
  always_comb begin
    pin_vec = 32'h0000_0000;
    pin_vec[31] = wake_pins_i.uart7_receive;
    pin_vec[30] = wake_pins_i.uart7_clear_to_send;
    pin_vec[28] = wake_pins_i.uart6_infrared_receive;
    pin_vec[26] = wake_pins_i.uart5_receive;
    pin_vec[25] = wake_pins_i.general_input_28;
    pin_vec[24] = wake_pins_i.uart3_receive;
    pin_vec[23] = wake_pins_i.uart2_clear_to_send;
    pin_vec[22] = wake_pins_i.uart2_receive;
    pin_vec[21] = wake_pins_i.uart1_receive;
    pin_vec[WAKE_CARD_INT_BIT] = wake_pins_i.card_data_lines[1];
    pin_vec[WAKE_CARD_OR_BIT]  = |wake_pins_i.card_data_lines;
    pin_vec[16:10] = wake_pins_i.general_input_hi;
    pin_vec[9] = wake_pins_i.external_clock_request_pin;
    pin_vec[8] = wake_pins_i.serial_port1_data_in;
    pin_vec[7] = wake_pins_i.general_input_7;
    pin_vec[6] = wake_pins_i.serial_port2_data_in;
    pin_vec[5:3] = wake_pins_i.general_input_lo;
  end

  // Enabled requests to the start controller
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pin_wake_request_o <= 32'h0000_0000;
    end else begin
      pin_wake_request_o <= pin_vec & wake_en_r;
    end
  end

  client_clock_gate #(.IDLE_CYCLES(USB_IDLE_CYCLES)) u_usb_gate (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .disable_i (gate_ctrl_r[USB_DIS_BIT]),
    .access_i  (usb_access_i),
    .clk_run_o (run[2]),
    .stall_o   (stall[2])
  );
  client_clock_gate #(.IDLE_CYCLES(RAM_IDLE_CYCLES)) u_ram_gate (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .disable_i (gate_ctrl_r[RAM_DIS_BIT]),
    .access_i  (ram_access_i),
    .clk_run_o (run[1]),
    .stall_o   (stall[1])
  );
  client_clock_gate #(.IDLE_CYCLES(ROM_IDLE_CYCLES)) u_rom_gate (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .disable_i (gate_ctrl_r[ROM_DIS_BIT]),
    .access_i  (rom_access_i),
    .clk_run_o (run[0]),
    .stall_o   (stall[0])
  );

  // Enables come from flops, so no glitch reaches a client's gate cell
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      usb_clk_en_o   <= 1'b1;
      ram_clk_en_o   <= 1'b1;
      rom_clk_en_o   <= 1'b1;
      client_stall_o <= 1'b0;
    end else begin
      usb_clk_en_o   <= run[2];
      ram_clk_en_o   <= run[1];
      rom_clk_en_o   <= run[0];
      client_stall_o <= |stall;
    end
  end
endmodule
`default_nettype wire

// *** testbench/acg_checker.sv ***
// Port checker for the clock gate and pin wake block.
// Assumes binding to the top module, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module acg_checker import acg_pkg::*; (
  input wire logic               clock_i,
  input wire logic               sys_rst_i,
  input wire logic               usb_access_i,
  input wire logic               ram_access_i,
  input wire logic               rom_access_i,
  input wire logic               usb_clk_en_o,
  input wire logic               ram_clk_en_o,
  input wire logic               rom_clk_en_o,
  input wire logic               client_stall_o,
  input wire acg_pkg::wake_pins_t wake_pins_i,
  input wire logic [31:0]        pin_wake_request_o
);
  logic [7:0] iu_r, ir_r, io_r;
  logic       any_acc;
  assign any_acc = usb_access_i | ram_access_i | rom_access_i;
  // Idle cycles seen since the last access of each client
  always_ff @(posedge clock_i) begin
    iu_r <= (sys_rst_i | usb_access_i) ? 8'h00 : iu_r + {7'h00, ~&iu_r};
    ir_r <= (sys_rst_i | ram_access_i) ? 8'h00 : ir_r + {7'h00, ~&ir_r};
    io_r <= (sys_rst_i | rom_access_i) ? 8'h00 : io_r + {7'h00, ~&io_r};
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  chk_usb_idle_stop: assert property (
    $fell(usb_clk_en_o) |-> $past(iu_r) >= 8'h80)
    else $error("usb stopped early");
  chk_ram_idle_stop: assert property (
    $fell(ram_clk_en_o) |-> $past(ir_r) >= 8'h10)
    else $error("ram stopped early");
  chk_rom_idle_stop: assert property (
    $fell(rom_clk_en_o) |-> $past(io_r) >= 8'h08)
    else $error("rom stopped early");
  chk_rom_restart: assert property (
    rom_access_i && !rom_clk_en_o |-> ##[1:3] rom_clk_en_o)
    else $error("rom clock not restarted");
  chk_stall_cause: assert property (
    $rose(client_stall_o) |-> $past(any_acc) || $past(any_acc, 2))
    else $error("stall without access");
  chk_wake_reserved: assert property (
    (pin_wake_request_o & ~WAKE_MASK) == 32'h0)
    else $error("wake request on unlisted bit");
  chk_card_or: assert property (
    pin_wake_request_o[17] |-> |$past(wake_pins_i.card_data_lines))
    else $error("card wake without data line");
  chk_card_int: assert property (
    pin_wake_request_o[18] |-> $past(wake_pins_i.card_data_lines[1]))
    else $error("card interrupt wake without line 1");
  chk_reset_state: assert property (
    $fell(sys_rst_i) |-> pin_wake_request_o == 32'h0 && usb_clk_en_o
      && ram_clk_en_o && rom_clk_en_o) else $error("bad state after reset");
endmodule
bind auto_clock_gate_and_pin_wake_enable acg_checker chk (.clock_i,
  .sys_rst_i, .usb_access_i, .ram_access_i, .rom_access_i, .usb_clk_en_o,
  .ram_clk_en_o, .rom_clk_en_o, .client_stall_o, .wake_pins_i,
  .pin_wake_request_o);
`default_nettype wire

// *** testbench/client_master.sv ***
// Bus master model: one-cycle client access per start, notes a stall.
// Assumes start_i pulses for one cycle; stall_i is the block's wait flag.
`timescale 1ns/100ps
`default_nettype none
module client_master (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic [2:0] start_i,
  input  wire logic       stall_i,
  output logic [2:0]      access_o,
  output logic            stalled_o
);
  always_ff @(posedge clock_i)
    access_o <= sys_rst_i ? 3'h0 : start_i;
  // Extra wait seen since the last start
  always_ff @(posedge clock_i)
    if (sys_rst_i || |start_i) stalled_o <= 1'b0;
    else if (stall_i) stalled_o <= 1'b1;
endmodule
`default_nettype wire

// *** testbench/auto_clock_gate_and_pin_wake_enable_test.sv ***
// Self-checking bench for the clock gate and pin wake block.
// Assumes the design files and acg_pkg are compiled first.
`timescale 1ns/100ps
`default_nettype none
module auto_clock_gate_and_pin_wake_enable_test;
  import acg_pkg::*;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  ahb_req_t req, ahb_i;
  logic [31:0] hwdata_i, hrdata_o, pin_wake_request_o, r, wm;
  logic hreadyout_o, hresp_o, client_stall_o, stalled;
  logic usb_access_i, ram_access_i, rom_access_i;
  logic usb_clk_en_o, ram_clk_en_o, rom_clk_en_o;
  logic [2:0] start;
  wake_pins_t wake_pins_i;
  int fail_count = 0;
  int compares = 0;
  int n[3] = '{ROM_IDLE_CYCLES, RAM_IDLE_CYCLES, USB_IDLE_CYCLES};
  int b[3] = '{ROM_DIS_BIT, RAM_DIS_BIT, USB_DIS_BIT};
  wire logic [2:0] en = {usb_clk_en_o, ram_clk_en_o, rom_clk_en_o};
  always #12.5 clock_i = ~clock_i;
  always_comb begin
    ahb_i = req;
    ahb_i.hready = hreadyout_o;
  end
  auto_clock_gate_and_pin_wake_enable dut (.clock_i, .sys_rst_i, .ahb_i,
    .hwdata_i, .hrdata_o, .hreadyout_o, .hresp_o, .usb_access_i,
    .ram_access_i, .rom_access_i, .usb_clk_en_o, .ram_clk_en_o,
    .rom_clk_en_o, .client_stall_o, .wake_pins_i, .pin_wake_request_o);
  client_master master (.clock_i, .sys_rst_i, .start_i(start),
    .stall_i(client_stall_o), .stalled_o(stalled),
    .access_o({usb_access_i, ram_access_i, rom_access_i}));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [31:0] a, logic [31:0] d);
    @(posedge clock_i);
    req <= '{a, 2'h2, wr, 3'h2, 1'b1, 1'b1};
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    req.htrans <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    r = hrdata_o;
  endtask
  task automatic hit(int k);
    @(posedge clock_i);
    start <= 3'h1 << k;
    @(posedge clock_i);
    start <= 3'h0;
  endtask
  function automatic logic [31:0] map(wake_pins_t p);
    map = {p.uart7_receive, p.uart7_clear_to_send, 1'b0,
      p.uart6_infrared_receive, 1'b0, p.uart5_receive, p.general_input_28,
      p.uart3_receive, p.uart2_clear_to_send, p.uart2_receive,
      p.uart1_receive, 2'h0, p.card_data_lines[1], |p.card_data_lines,
      p.general_input_hi, p.external_clock_request_pin,
      p.serial_port1_data_in, p.general_input_7, p.serial_port2_data_in,
      p.general_input_lo, 3'h0};
  endfunction
  task automatic test_done;
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    test_done();
  end
  initial begin
    req = '0;
    hwdata_i = 32'h0;
    start = 3'h0;
    wake_pins_i = '0;
    void'($urandom(32'h37EA8026));
    repeat (2) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    check("clk_en reset", {29'h0, en}, 32'h7);
    check("bus idle", {30'h0, hreadyout_o, hresp_o}, 32'h2);
    bus(1'b0, AUTO_CLOCK_GATING_CONTROL_ADDR, 32'h0);
    check("gate reset", r, 32'h0);
    bus(1'b0, PIN_WAKE_SOURCE_ENABLE_ADDR, 32'h0);
    check("wake reset", r, 32'h0);
    bus(1'b0, 32'h4000_4000, 32'h0);
    check("unmapped", r, 32'h0);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, AUTO_CLOCK_GATING_CONTROL_ADDR, 32'h0);
      hit(k);
      repeat (n[k] + 2) @(posedge clock_i);
      check("clk early", en[k], 1'b1);
      repeat (1) @(posedge clock_i);
      check("clk stop", en[k], 1'b0);
      hit(k);
      repeat (5) @(posedge clock_i);
      check("stall", stalled, 1'b1);
      check("restart", en[k], 1'b1);
      hit(k);
      repeat (4) @(posedge clock_i);
      check("no stall", stalled, 1'b0);
      bus(1'b1, AUTO_CLOCK_GATING_CONTROL_ADDR, 32'h1 << b[k]);
      repeat (n[k] + 6) @(posedge clock_i);
      check("kept on", en[k], 1'b1);
      bus(1'b0, AUTO_CLOCK_GATING_CONTROL_ADDR, 32'h0);
      check("gate reg", r, 32'h1 << b[k]);
    end
    repeat (12) begin
      wm = $urandom & WAKE_MASK;
      bus(1'b1, PIN_WAKE_SOURCE_ENABLE_ADDR, wm);
      wake_pins_i <= 27'($urandom);
      repeat (3) @(posedge clock_i);
      check("wake req", pin_wake_request_o, map(wake_pins_i) & wm);
      bus(1'b0, PIN_WAKE_SOURCE_ENABLE_ADDR, 32'h0);
      check("wake reg", r, wm);
    end
    test_done();
  end
endmodule
`default_nettype wire
